// ---- core/mbpa_regs.svh ----
// constants of the modbus parameter access engine
`ifndef MBPA_REGS_SVH
`define MBPA_REGS_SVH
`define MBPA_FC_RD_COILS   8'h01
`define MBPA_FC_RD_DISC    8'h02
`define MBPA_FC_RD_HOLD    8'h03
`define MBPA_FC_RD_INPUT   8'h04
`define MBPA_FC_WR_ONE     8'h06
`define MBPA_FC_WR_COILS   8'h0F
`define MBPA_FC_WR_MULTI   8'h10
`define MBPA_FC_DEV_ID     8'h2B
`define MBPA_EXC_FLAG      8'h80
`define MBPA_EXC_FUNC      8'h01
`define MBPA_EXC_ADDR      8'h02
`define MBPA_EXC_VALUE     8'h03
`define MBPA_MEI_TYPE      8'h0E
`define MBPA_ID_BASIC      8'h01
`define MBPA_ID_OBJECTS    8'h03
`define MBPA_ID_OBJ_LEN    8'h02
`define MBPA_HDR_RD        8'h05
`define MBPA_HDR_WR_ONE    8'h05
`define MBPA_HDR_WR_MULTI  8'h06
`define MBPA_HDR_DEV_ID    8'h04
`define MBPA_HDR_UNKNOWN   8'h01
`define MBPA_LEN_ECHO      8'h05
`define MBPA_LEN_EXC       8'h02
`define MBPA_LEN_ID        8'h13
`define MBPA_LEN_MST       8'h05
`define MBPA_LEN_MST_COIL  8'h06
`define MBPA_RD_MAX_QTY    16'h007D
`define MBPA_WR_MAX_QTY    16'h007B
`define MBPA_MST_MAX_QTY   16'h0010
`define MBPA_PAR_BASE      16'h3D60
`define MBPA_PAR_COUNT     16'h0008
`define MBPA_IDX_FLAG      3'h7
`define MBPA_IDX_MODEL     3'h5
`define MBPA_DEFAULTS      128'h0000_0000_0801_0000_0000_0000_0064_0000
`define MBPA_MIN_VEC       128'h0000_0000_0000_0000_0000_FC18_0000_D8F1
`define MBPA_MAX_VEC       128'h0001_0001_FFFF_FFFF_FFFF_03E8_03E8_270F
`define MBPA_SIGNED_MASK   8'h05
`define MBPA_REBOOT_MASK   8'h30
`endif

// ---- core/mbpa_pkg.sv ----
// types of the modbus parameter access engine
package mbpa_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_CHECK = 3'b010,
    ST_WDATA = 3'b011,
    ST_DRAIN = 3'b100,
    ST_RESP  = 3'b101
  } mbpa_state_e;
  typedef enum logic [2:0] {
    RK_READ = 3'b000,
    RK_ECHO = 3'b001,
    RK_ID   = 3'b010,
    RK_EXC  = 3'b011,
    RK_MST  = 3'b100
  } mbpa_resp_e;
  typedef logic [15:0] mbpa_word_t;
  typedef struct packed {logic valid; logic last; logic [7:0] data;} mbpa_byte_s;
  typedef struct packed {logic valid; logic [7:0] func; mbpa_word_t addr; mbpa_word_t qty; mbpa_word_t coils;} mbpa_mreq_s;
  typedef struct packed {logic en; logic [2:0] idx; mbpa_word_t data;} mbpa_wr_s;
endpackage : mbpa_pkg

// ---- core/mbpa_param_store.sv ----
// parameter table: stored image, active values and modified flag
`timescale 1ns/1ps
`default_nettype none
`include "mbpa_regs.svh"
module mbpa_param_store (
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire mbpa_pkg::mbpa_wr_s wr_in,
  input  wire logic              restart_in,
  input  wire logic [2:0]        rd_idx_in,
  output wire logic [15:0]       rd_data_out,
  output wire logic [127:0]      active_out,
  output wire logic              modified_out
);
  import mbpa_pkg::*;
  logic [7:0][15:0] stored_reg;
  logic [7:0][15:0] active_reg;
  logic [7:0][15:0] stored_next;
  logic [7:0][15:0] active_next;
  logic             modified_reg;
  logic             modified_next;
  localparam logic [127:0] DEFS     = `MBPA_DEFAULTS;
  localparam logic [7:0]   REBOOT_M = `MBPA_REBOOT_MASK;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ent
      wire hit = wr_in.en && wr_in.idx == 3'(g) && 3'(g) != `MBPA_IDX_FLAG;
      assign stored_next[g] = hit ? wr_in.data : stored_reg[g];
      // reboot entries keep the old value live until the next restart
      assign active_next[g] = (hit && !REBOOT_M[g]) ? wr_in.data : // [R10]
                              (restart_in ? stored_reg[g] : active_reg[g]); // [R9]
    end
  endgenerate
  assign modified_next = stored_next[6:0] != DEFS[111:0]; // [R15]
  assign rd_data_out   = (rd_idx_in == `MBPA_IDX_FLAG) ? {15'h0000, modified_reg} : stored_reg[rd_idx_in];
  assign active_out    = {15'h0000, modified_reg, active_reg[6:0]};
  assign modified_out  = modified_reg;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stored_reg   <= `MBPA_DEFAULTS; // [R14]
      active_reg   <= `MBPA_DEFAULTS;
      modified_reg <= 1'b0;
    end else begin
      stored_reg   <= stored_next;
      active_reg   <= active_next;
      modified_reg <= modified_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  reboot_hold_a: assert property (wr_in.en && REBOOT_M[wr_in.idx] && !restart_in // [R9]
    |=> active_reg[$past(wr_in.idx)] == $past(active_reg[wr_in.idx]))
    else $error("reboot parameter changed without restart");
  restart_load_a: assert property (restart_in && !wr_in.en |=> active_reg[5:4] == $past(stored_reg[5:4])) // [R9]
    else $error("restart did not load stored values");
  live_update_a: assert property (wr_in.en && !REBOOT_M[wr_in.idx] && wr_in.idx != `MBPA_IDX_FLAG // [R10]
    |=> active_reg[$past(wr_in.idx)] == $past(wr_in.data))
    else $error("live parameter not updated");
  modified_set_a: assert property (wr_in.en && wr_in.idx != `MBPA_IDX_FLAG // [R15]
    && wr_in.data != DEFS[{wr_in.idx, 4'h0} +: 16] |=> modified_out)
    else $error("modified flag not raised");
endmodule : mbpa_param_store
`default_nettype wire

// ---- core/mbpa_modbus_access.sv ----
// modbus parameter access engine: slave pdu interpreter and master request issue
//
// Overview of operation
// [R1] answer read holding registers with register contents
// [R2] write single register updates addressed parameter
// [R3] write multiple registers updates consecutive parameters
// [R4] device id returns manufacturer, model, version
// [R5] master issues codes 1,2,4,15, max 16
// [R6] reader keeps 0..32767 as non-negative value
// [R7] reader subtracts 65536 from 32768..65535
// [R8] per-parameter signed attribute marks two's complement
// [R9] reboot parameters take effect after client restart
// [R10] other parameters take effect immediately
// [R11] configuration kept in non-volatile storage; code only mirrors writes on NVM_WR_OUT and reset reloads defaults
// [R12] each parameter has fixed address and width
// [R13] each parameter has permitted value interval
// [R14] factory default held until changed
// [R15] modified flag set when differing from defaults
// [R16] unsupported function gets illegal function exception
`timescale 1ns/1ps
`default_nettype none
`include "mbpa_regs.svh"
module mbpa_modbus_access #(
  parameter logic [15:0] MANUF_ID   = 16'h5A5A, // arbitrary value
  parameter logic [15:0] VERSION_ID = 16'h0100  // arbitrary value
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 ARST_N_IN,
  input  wire mbpa_pkg::mbpa_byte_s RX_IN,
  output wire logic                 RX_READY_OUT,
  output wire mbpa_pkg::mbpa_byte_s TX_OUT,
  input  wire logic                 TX_READY_IN,
  input  wire mbpa_pkg::mbpa_mreq_s MST_REQ_IN,
  output wire logic                 MST_READY_OUT,
  output var  logic                 MST_REJECT_OUT,
  output wire mbpa_pkg::mbpa_byte_s MST_RSP_OUT,
  input  wire logic                 RESTART_IN,
  output wire logic [127:0]         PARAM_ACTIVE_OUT,
  output wire logic                 PARAM_MODIFIED_OUT,
  output wire mbpa_pkg::mbpa_wr_s   NVM_WR_OUT
);
  import mbpa_pkg::*;

  localparam logic [7:0]   SIGNED_M = `MBPA_SIGNED_MASK;
  localparam logic [127:0] MIN_V    = `MBPA_MIN_VEC;
  localparam logic [127:0] MAX_V    = `MBPA_MAX_VEC;

  function automatic logic [7:0] hdr_need(input logic [7:0] f);
    case (f)
      `MBPA_FC_RD_HOLD:  hdr_need = `MBPA_HDR_RD;
      `MBPA_FC_WR_ONE:   hdr_need = `MBPA_HDR_WR_ONE;
      `MBPA_FC_WR_MULTI: hdr_need = `MBPA_HDR_WR_MULTI;
      `MBPA_FC_DEV_ID:   hdr_need = `MBPA_HDR_DEV_ID;
      default:           hdr_need = `MBPA_HDR_UNKNOWN;
    endcase
  endfunction : hdr_need

  function automatic logic in_limits(input logic [2:0] i, input logic [15:0] v);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = MIN_V[{i, 4'h0} +: 16];
    hi = MAX_V[{i, 4'h0} +: 16];
    // signed entries compare as two's complement
    if (SIGNED_M[i]) // [R8]
      in_limits = $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
    else
      in_limits = v >= lo && v <= hi;
  endfunction : in_limits

  function automatic logic [7:0] id_byte(input logic [7:0] n, input logic [15:0] mdl);
    case (n)
      8'h00:   id_byte = `MBPA_FC_DEV_ID;
      8'h01:   id_byte = `MBPA_MEI_TYPE;
      8'h02,
      8'h03:   id_byte = `MBPA_ID_BASIC;
      8'h06:   id_byte = `MBPA_ID_OBJECTS;
      8'h08,
      8'h0C,
      8'h10:   id_byte = `MBPA_ID_OBJ_LEN;
      8'h09:   id_byte = MANUF_ID[15:8];
      8'h0A:   id_byte = MANUF_ID[7:0];
      8'h0B:   id_byte = 8'h01;
      8'h0D:   id_byte = mdl[15:8];
      8'h0E:   id_byte = mdl[7:0];
      8'h0F:   id_byte = 8'h02;
      8'h11:   id_byte = VERSION_ID[15:8];
      8'h12:   id_byte = VERSION_ID[7:0];
      default: id_byte = 8'h00;
    endcase
  endfunction : id_byte

  mbpa_state_e     state_reg;
  mbpa_resp_e      kind_reg;
  logic [5:0][7:0] h_reg;
  logic [7:0]      cnt_reg;
  logic [7:0]      len_reg;
  logic [7:0]      exc_reg;
  logic [7:0]      wbyte_reg;
  logic [15:0]     coils_reg;
  logic [6:0]      widx_reg;
  logic            seen_last_reg;
  logic            lo_reg;
  logic            bad_val_reg;
  logic            mst_wait_reg;
  mbpa_byte_s      tx_reg;
  mbpa_byte_s      mrsp_reg;
  mbpa_wr_s        nvm_reg;
  mbpa_wr_s        wr;
  logic [15:0]     rd_word;
  logic [127:0]    active;
  logic [7:0]      chk_exc;
  logic [7:0]      resp_byte;

  wire [7:0]  fc         = h_reg[0];
  wire [15:0] addr       = {h_reg[1], h_reg[2]};
  wire [15:0] qty        = {h_reg[3], h_reg[4]};
  wire [15:0] off        = addr - `MBPA_PAR_BASE; // [R12]
  wire [16:0] blk_end    = {1'b0, off} + {1'b0, qty};
  wire        above_base = addr >= `MBPA_PAR_BASE;
  wire        single_ok  = above_base && off < `MBPA_PAR_COUNT && off[2:0] != `MBPA_IDX_FLAG;
  wire        blk_ok     = above_base && blk_end <= {1'b0, `MBPA_PAR_COUNT};
  wire        rd_qty_ok  = qty != 16'h0000 && qty <= `MBPA_RD_MAX_QTY;
  wire        wr_qty_ok  = qty != 16'h0000 && qty <= `MBPA_WR_MAX_QTY && h_reg[5] == {qty[6:0], 1'b0};
  wire        short_hdr  = seen_last_reg && cnt_reg < hdr_need(fc);
  wire        rx_take    = RX_IN.valid && RX_READY_OUT;
  wire [2:0]  widx_idx   = off[2:0] + widx_reg[2:0];
  wire [15:0] wval       = {wbyte_reg, RX_IN.data};
  wire        wr_lo      = state_reg == ST_WDATA && rx_take && lo_reg;
  wire        wval_ok    = in_limits(widx_idx, wval);
  wire        wdone      = wr_lo && (widx_reg + 7'h01) == qty[6:0];
  wire        wr_single  = state_reg == ST_CHECK && fc == `MBPA_FC_WR_ONE && chk_exc == 8'h00;
  wire [7:0]  rd_half    = (cnt_reg - 8'h02) >> 1;
  wire [2:0]  rd_idx     = off[2:0] + rd_half[2:0];
  wire [7:0]  m_func     = MST_REQ_IN.func;
  wire        m_code_ok  = m_func == `MBPA_FC_RD_COILS || m_func == `MBPA_FC_RD_DISC
                        || m_func == `MBPA_FC_RD_INPUT || m_func == `MBPA_FC_WR_COILS;
  wire        mst_ok     = m_code_ok && MST_REQ_IN.qty != 16'h0000 && MST_REQ_IN.qty <= `MBPA_MST_MAX_QTY;
  wire [7:0]  m_bytes    = (MST_REQ_IN.qty[7:0] + 8'h07) >> 3;
  wire [7:0]  m_len      = (m_func == `MBPA_FC_WR_COILS) ? `MBPA_LEN_MST_COIL + m_bytes : `MBPA_LEN_MST;
  wire [7:0]  c_bytes    = (qty[7:0] + 8'h07) >> 3;
  wire        mst_take   = MST_REQ_IN.valid && MST_READY_OUT;

  // drain stops taking bytes once the frame end is seen so the next frame waits
  assign RX_READY_OUT  = state_reg == ST_IDLE || state_reg == ST_HDR || state_reg == ST_WDATA
                      || (state_reg == ST_DRAIN && !seen_last_reg);
  assign MST_READY_OUT = state_reg == ST_IDLE && !RX_IN.valid && !mst_wait_reg;
  assign wr.en   = wr_single || (wr_lo && wval_ok); // [R2] [R3] [R13]
  assign wr.idx  = wr_single ? off[2:0] : widx_idx;
  assign wr.data = wr_single ? qty : wval;
  assign TX_OUT             = tx_reg;
  assign MST_RSP_OUT        = mrsp_reg;
  assign NVM_WR_OUT         = nvm_reg;
  assign PARAM_ACTIVE_OUT   = active;

  always_comb begin
    chk_exc = 8'h00;
    case (fc)
      `MBPA_FC_RD_HOLD:  chk_exc = (short_hdr || !rd_qty_ok) ? `MBPA_EXC_VALUE : (!blk_ok ? `MBPA_EXC_ADDR : 8'h00);
      `MBPA_FC_WR_ONE:   chk_exc = short_hdr ? `MBPA_EXC_VALUE : (!single_ok ? `MBPA_EXC_ADDR : // [R13]
                                   (!in_limits(off[2:0], qty) ? `MBPA_EXC_VALUE : 8'h00));
      `MBPA_FC_WR_MULTI: chk_exc = (seen_last_reg || !wr_qty_ok) ? `MBPA_EXC_VALUE : (!blk_ok ? `MBPA_EXC_ADDR : 8'h00);
      `MBPA_FC_DEV_ID:   chk_exc = (short_hdr || h_reg[1] != `MBPA_MEI_TYPE || h_reg[2] != `MBPA_ID_BASIC)
                                   ? `MBPA_EXC_VALUE : 8'h00;
      default:           chk_exc = `MBPA_EXC_FUNC; // [R16]
    endcase
  end

  always_comb begin
    resp_byte = 8'h00;
    case (kind_reg)
      RK_READ: resp_byte = (cnt_reg == 8'h00) ? `MBPA_FC_RD_HOLD : (cnt_reg == 8'h01) ? len_reg - 8'h02 : // [R1]
                           (cnt_reg[0] ? rd_word[7:0] : rd_word[15:8]);
      RK_ECHO: resp_byte = h_reg[cnt_reg[2:0]];
      RK_EXC:  resp_byte = (cnt_reg == 8'h00) ? (fc | `MBPA_EXC_FLAG) : exc_reg;
      RK_ID:   resp_byte = id_byte(cnt_reg, active[{`MBPA_IDX_MODEL, 4'h0} +: 16]); // [R4]
      RK_MST:  resp_byte = (cnt_reg == 8'h05) ? c_bytes : (cnt_reg == 8'h06) ? coils_reg[7:0] :
                           (cnt_reg == 8'h07) ? coils_reg[15:8] : h_reg[cnt_reg[2:0]];
      default: resp_byte = 8'h00;
    endcase
  end

  // stored image defaults at power-up; persistence is kept by the external nvm mirror
  mbpa_param_store u_store (
    .clk_in       (CORE_CLK_IN),
    .arst_n_in    (ARST_N_IN),
    .wr_in        (wr),
    .restart_in   (RESTART_IN),
    .rd_idx_in    (rd_idx),
    .rd_data_out  (rd_word),
    .active_out   (active),
    .modified_out (PARAM_MODIFIED_OUT)
  );

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_reg <= ST_IDLE;
      kind_reg <= RK_EXC;
      h_reg <= '0;
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
      exc_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      coils_reg <= 16'h0000;
      widx_reg <= 7'h00;
      seen_last_reg <= 1'b0;
      lo_reg <= 1'b0;
      bad_val_reg <= 1'b0;
      mst_wait_reg <= 1'b0;
      tx_reg <= '0;
      mrsp_reg <= '0;
      nvm_reg <= '0;
      MST_REJECT_OUT <= 1'b0;
    end else begin
      MST_REJECT_OUT <= 1'b0;
      mrsp_reg <= '0;
      nvm_reg <= wr; // [R11]
      case (state_reg)
        ST_IDLE: begin
          if (rx_take && mst_wait_reg) begin
            mrsp_reg <= RX_IN;
            mst_wait_reg <= !RX_IN.last;
          end else if (rx_take) begin
            h_reg <= {40'h00_0000_0000, RX_IN.data};
            cnt_reg <= 8'h01;
            seen_last_reg <= RX_IN.last;
            state_reg <= (RX_IN.last || hdr_need(RX_IN.data) == `MBPA_HDR_UNKNOWN) ? ST_CHECK : ST_HDR;
          end else if (mst_take && mst_ok) begin // [R5]
            h_reg <= {8'h00, MST_REQ_IN.qty[7:0], MST_REQ_IN.qty[15:8], MST_REQ_IN.addr[7:0], MST_REQ_IN.addr[15:8], m_func};
            coils_reg <= MST_REQ_IN.coils;
            kind_reg <= RK_MST;
            len_reg <= m_len;
            cnt_reg <= 8'h00;
            mst_wait_reg <= 1'b1;
            state_reg <= ST_RESP;
          end else if (mst_take) begin
            MST_REJECT_OUT <= 1'b1; // [R5]
          end
        end
        ST_HDR: begin
          if (rx_take) begin
            h_reg[cnt_reg[2:0]] <= RX_IN.data;
            cnt_reg <= cnt_reg + 8'h01;
            seen_last_reg <= RX_IN.last;
            if (RX_IN.last || (cnt_reg + 8'h01) == hdr_need(fc))
              state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          cnt_reg <= 8'h00;
          lo_reg <= 1'b0;
          widx_reg <= 7'h00;
          bad_val_reg <= 1'b0;
          exc_reg <= chk_exc;
          if (chk_exc != 8'h00) begin
            kind_reg <= RK_EXC; // [R16]
            len_reg <= `MBPA_LEN_EXC;
          end else if (fc == `MBPA_FC_RD_HOLD) begin
            kind_reg <= RK_READ; // [R1]
            len_reg <= {qty[6:0], 1'b0} + 8'h02;
          end else if (fc == `MBPA_FC_DEV_ID) begin
            kind_reg <= RK_ID;
            len_reg <= `MBPA_LEN_ID;
          end else begin
            kind_reg <= RK_ECHO;
            len_reg <= `MBPA_LEN_ECHO;
          end
          if (chk_exc == 8'h00 && fc == `MBPA_FC_WR_MULTI)
            state_reg <= ST_WDATA; // [R3]
          else
            state_reg <= seen_last_reg ? ST_RESP : ST_DRAIN;
        end
        ST_WDATA: begin
          if (rx_take) begin
            lo_reg <= !lo_reg;
            seen_last_reg <= RX_IN.last;
            if (!lo_reg)
              wbyte_reg <= RX_IN.data;
            if (wr_lo)
              widx_reg <= widx_reg + 7'h01;
            if (wr_lo && !wval_ok)
              bad_val_reg <= 1'b1;
            if (wdone || RX_IN.last) begin
              state_reg <= RX_IN.last ? ST_RESP : ST_DRAIN;
              // out of range words are skipped; the rest of the block still lands
              if (bad_val_reg || (wr_lo && !wval_ok) || !wdone) begin
                kind_reg <= RK_EXC; // [R13]
                exc_reg <= `MBPA_EXC_VALUE;
                len_reg <= `MBPA_LEN_EXC;
              end
            end
          end
        end
        ST_DRAIN: begin
          if (seen_last_reg || (rx_take && RX_IN.last))
            state_reg <= ST_RESP;
        end
        ST_RESP: begin
          if (!tx_reg.valid || TX_READY_IN) begin
            if (cnt_reg < len_reg) begin
              tx_reg <= '{valid: 1'b1, last: (cnt_reg + 8'h01) == len_reg, data: resp_byte};
              cnt_reg <= cnt_reg + 8'h01;
            end else begin
              tx_reg <= '0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence check_ok(logic [7:0] c);
    state_reg == ST_CHECK && fc == c && chk_exc == 8'h00;
  endsequence
  sequence last_beat;
    TX_OUT.valid && TX_OUT.last && TX_READY_IN;
  endsequence
  rd_len_a: assert property (check_ok(`MBPA_FC_RD_HOLD) |=> kind_reg == RK_READ // [R1]
    && len_reg == {qty[6:0], 1'b0} + 8'h02 && state_reg == ($past(seen_last_reg) ? ST_RESP : ST_DRAIN))
    else $error("read reply length wrong");
  tx_hold_a: assert property (tx_reg.valid && !TX_READY_IN |=> $stable(tx_reg)) // [R1]
    else $error("reply byte changed while stalled");
  resp_end_a: assert property (last_beat |=> !TX_OUT.valid && state_reg == ST_IDLE) // [R1]
    else $error("reply did not end after last byte");
  wr_one_a: assert property (check_ok(`MBPA_FC_WR_ONE) |-> wr.en && wr.data == qty // [R2]
    && wr.idx == off[2:0] ##1 NVM_WR_OUT.en)
    else $error("single write not applied");
  wr_multi_a: assert property (check_ok(`MBPA_FC_WR_MULTI) |=> state_reg == ST_WDATA && widx_reg == 7'h00) // [R3]
    else $error("multi write did not start");
  id_len_a: assert property (check_ok(`MBPA_FC_DEV_ID) |=> kind_reg == RK_ID && len_reg == `MBPA_LEN_ID) // [R4]
    else $error("id reply length wrong");
  mst_issue_a: assert property (mst_take && mst_ok |=> state_reg == ST_RESP && kind_reg == RK_MST) // [R5]
    else $error("master request not issued");
  mst_reject_a: assert property (mst_take && !mst_ok |=> MST_REJECT_OUT && state_reg == ST_IDLE) // [R5]
    else $error("bad master request not refused");
  range_a: assert property (wr.en |-> in_limits(wr.idx, wr.data)) // [R13]
    else $error("out of range value written");
  nvm_mirror_a: assert property (wr.en |=> NVM_WR_OUT.en && NVM_WR_OUT.data == $past(wr.data)) // [R11]
    else $error("write not mirrored to nvm");
  exc_func_a: assert property (state_reg == ST_CHECK && hdr_need(fc) == `MBPA_HDR_UNKNOWN // [R16]
    |-> !wr.en ##1 kind_reg == RK_EXC && exc_reg == `MBPA_EXC_FUNC)
    else $error("unsupported code not refused");
endmodule : mbpa_modbus_access
`default_nettype wire

// ---- sim/mbpa_client_model.sv ----
// bus client model: sends request frames and takes reply bytes, stalling on request
`timescale 1ns/1ps
`default_nettype none
module mbpa_client_model (
  input  wire logic                 clk_in,
  input  wire logic                 rx_ready_in,
  input  wire mbpa_pkg::mbpa_byte_s tx_in,
  output var  mbpa_pkg::mbpa_byte_s rx_out,
  output var  logic                 tx_ready_out
);
  import mbpa_pkg::*;
  logic [7:0] got_q[$];
  bit         slow = 1'b0;
  int         n_timeout = 0;
  initial rx_out = '{1'b0, 1'b0, 8'hFF};
  initial tx_ready_out = 1'b1;
  // slow mode halves the sink rate to exercise reply stalls
  always @(negedge clk_in) tx_ready_out <= !slow || !tx_ready_out;
  always @(posedge clk_in) if (tx_in.valid && tx_ready_out) got_q.push_back(tx_in.data);
  // idle data inverted so a stale byte never passes for a fresh one
  task automatic send(input logic [95:0] rq, input int n);
    bit ok;
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      rx_out = '{1'b1, i == n - 1, rq[8*(n-1-i) +: 8]};
      k = 0;
      do begin
        #1 ok = rx_ready_in;
        @(posedge clk_in);
        if (!ok) @(negedge clk_in);
        k++;
      end while (!ok && k < 100);
      if (!ok) n_timeout++;
    end
    @(negedge clk_in);
    rx_out = '{1'b0, 1'b0, ~rx_out.data};
  endtask : send
endmodule : mbpa_client_model
`default_nettype wire

// ---- sim/mbpa_tb.sv ----
// self-checking bench of the parameter access engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mbpa_pkg::*;
  typedef struct packed {logic [95:0] rq; int nq; logic [191:0] rp; int np;} mbpa_row_s;
  localparam mbpa_row_s ROWS [9] = '{
    '{96'h033D600002, 5, 192'h030400000064, 6},
    '{96'h063D60FFFF, 5, 192'h063D60FFFF, 5},
    '{96'h033D600001, 5, 192'h0302FFFF, 4},
    '{96'h103D61000204000A0005, 10, 192'h103D610002, 5},
    '{96'h033D610002, 5, 192'h0304000A0005, 6},
    '{96'h2B0E0100, 4, 192'h2B0E010100000300025A5A010208010202_0100, 19},
    '{96'h05, 1, 192'h8501, 2},
    '{96'h063D6103E9, 5, 192'h8603, 2},
    '{96'h033D700001, 5, 192'h8302, 2}};
  logic         clk, arst_n, restart, rx_ready, tx_ready, mready, mrej, modified, rej;
  mbpa_byte_s   rx, tx, mrsp;
  mbpa_mreq_s   mreq;
  mbpa_wr_s     nvm;
  logic [127:0] active;
  logic [18:0]  nvm_last;
  logic [8:0]   m_tail;
  int           n_mismatch = 0;
  int           total_checks = 0;
  int           n_rsp = 0;
  logic [7:0]   f;
  mbpa_modbus_access i_dut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .RX_IN(rx), .RX_READY_OUT(rx_ready),
    .TX_OUT(tx), .TX_READY_IN(tx_ready), .MST_REQ_IN(mreq), .MST_READY_OUT(mready), .MST_REJECT_OUT(mrej),
    .MST_RSP_OUT(mrsp), .RESTART_IN(restart), .PARAM_ACTIVE_OUT(active), .PARAM_MODIFIED_OUT(modified),
    .NVM_WR_OUT(nvm));
  mbpa_client_model i_client (.clk_in(clk), .rx_ready_in(rx_ready), .tx_in(tx), .rx_out(rx),
    .tx_ready_out(tx_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (nvm.en) nvm_last <= {nvm.idx, nvm.data};
  always @(posedge clk) begin
    if (mrsp.valid) begin
      n_rsp++;
      m_tail <= {mrsp.last, mrsp.data};
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic reply(input logic [191:0] rp, input int np);
    int k = 0;
    while (i_client.got_q.size() < np && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (i_client.got_q.size() < np) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (4) @(negedge clk);
    chk("reply length", np, i_client.got_q.size());
    for (int i = 0; i < np && i < i_client.got_q.size(); i++) begin
      chk("reply byte", rp[8*(np-1-i) +: 8], i_client.got_q[i]);
    end
    i_client.got_q.delete();
  endtask : reply
  task automatic send_chk(input logic [95:0] rq, input int n);
    i_client.send(rq, n);
    if (i_client.n_timeout != 0) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : send_chk
  task automatic mst(input logic [7:0] fc, input logic [15:0] q, output logic rj);
    bit ok;
    int k = 0;
    @(negedge clk);
    mreq = '{1'b1, fc, 16'h0000, q, 16'h1234};
    do begin
      #1 ok = mready;
      @(posedge clk);
      if (!ok) @(negedge clk);
      k++;
    end while (!ok && k < 100);
    if (!ok) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(negedge clk);
    rj = mrej;
    mreq.valid = 1'b0;
  endtask : mst
  function automatic int sconv(input logic [15:0] v);
    return v > 32767 ? int'(v) - 65536 : int'(v);
  endfunction : sconv
  initial begin
    arst_n = 1'b0;
    restart = 1'b0;
    mreq = '0;
    repeat (8) @(negedge clk);
    chk("tx valid in reset", 0, tx.valid);
    chk("default idx1", 32'h64, active[31:16]);
    chk("modified in reset", 0, modified);
    arst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      i_client.slow = i[0];
      send_chk(ROWS[i].rq, ROWS[i].nq);
      reply(ROWS[i].rp, ROWS[i].np);
    end
    chk("live idx0", 32'hFFFF, active[15:0]);
    chk("positive read", 10, sconv(active[31:16]));
    chk("negative read", -1, sconv(active[15:0]));
    chk("modified set", 1, modified);
    send_chk(96'h063D640007, 5);
    reply(192'h063D640007, 5);
    chk("reboot param held", 0, active[79:64]);
    chk("stored write", {3'h4, 16'h0007}, nvm_last);
    @(negedge clk);
    restart = 1'b1;
    @(negedge clk);
    restart = 1'b0;
    @(negedge clk);
    chk("reboot param live", 7, active[79:64]);
    mst(8'h01, 16'd17, rej);
    chk("reject count", 1, rej);
    mst(8'h03, 16'd1, rej);
    chk("reject code", 1, rej);
    for (int j = 0; j < 4; j++) begin
      f = j == 3 ? 8'h0F : j == 2 ? 8'h04 : 8'(j + 1);
      mst(f, 16'd16, rej);
      chk("accept", 0, rej);
      if (f == 8'h0F) reply({f, 32'h00000010, 24'h023412}, 8);
      else reply({f, 32'h00000010}, 5);
      send_chk(96'h0102AA55, 4);
      repeat (4) @(negedge clk);
      chk("master reply bytes", 4 * (j + 1), n_rsp);
      chk("master reply tail", 9'h155, m_tail);
    end
    arst_n = 1'b0;
    @(negedge clk);
    chk("modified after reset", 0, modified);
    chk("idx0 after reset", 0, active[15:0]);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("ready after reset", 1, rx_ready);
    chk("master ready after reset", 1, mready);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
